// [asp_angle_out.sv]
// Angle output block: three-wire or two-wire serial port on the link clock plus a pulse-width output.
module asp_angle_out
    import asp_pkg::*;
(
    // Core clock, reset and enable.
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    // Serial link.
    input  wire logic       link_clk_in,
    input  wire logic       cs_n_in,
    input  wire logic       serial_data_line_in,
    output logic            serial_data_line_out,
    output logic            serial_data_line_oe_out,
    // Mode pins and stored gain.
    input  wire logic       link_mode_in,
    input  wire logic       pwm_iface_in,
    input  wire logic [2:0] otp_gain_in,
    // Measured angle.
    input  wire logic [7:0] angle_in,
    input  wire logic       angle_valid_in,
    input  wire logic       lock_in,
    input  wire logic [5:0] agc_in,
    // Results.
    output logic            pwm_out,
    output logic [2:0]      gain_out,
    output logic [6:0]      wake_thresh_out,
    output logic            sleep_out,
    output logic            two_wire_out
);

    // Even parity bit over the fifteen upper bits of a read word.
    function automatic logic even_par(input logic [14:0] bits);
        even_par = ^bits;
    endfunction

    // Core-domain state.
    logic        cs_n_s1_reg;
    logic        cs_n_s2_reg;
    logic        mode_s1_reg;
    logic        mode_s2_reg;
    logic        pwmi_s1_reg;
    logic        pwmi_s2_reg;
    logic        lclk_s1_reg;
    logic        lclk_s2_reg;
    logic        lclk_s3_reg;
    logic        wtog_s1_reg;
    logic        wtog_s2_reg;
    logic        wtog_s3_reg;
    logic        frame_reg;
    logic [9:0]  tmo_reg;
    logic        abort_reg;
    logic        gain_ld_reg;
    logic        sleep_req_reg;
    logic [15:0] angle_word_reg;
    logic [15:0] cust_word_reg;

    // Link-domain state.
    logic [4:0]  cnt_reg;
    logic [4:0]  cmd_reg;
    logic [15:0] wsh_reg;
    logic [15:0] wdata_reg;
    logic [4:0]  wcmd_reg;
    logic        wtog_reg;
    logic [15:0] rsh_reg;

    // Link logic is held in reset outside a frame, and by a one-cycle timeout abort.
    wire logic link_rst_n = resetn_in & ~cs_n_in & ~abort_reg;

    // Command decode on the link side.
    wire logic is_read  = ~cmd_reg[4];
    wire logic is_ext   = (cmd_reg[4:3] == CMD_EXT_TOP);
    wire logic is_write = cmd_reg[4] & ~is_ext;
    wire logic [15:0] rd_word = (cmd_reg == CMD_RD_ANGLE) ? angle_word_reg :
                                (cmd_reg == CMD_RD_CUST)  ? cust_word_reg  : 16'h0000;

    // Core-side decode of pin events and finished writes.
    wire logic lclk_rise = lclk_s2_reg & ~lclk_s3_reg;
    wire logic wr_evt    = wtog_s2_reg ^ wtog_s3_reg;
    wire logic tmo_hit   = two_wire_out && frame_reg && (tmo_reg == 10'(TMO_CYC - 1));
    wire logic idle      = cs_n_s2_reg | (two_wire_out & ~frame_reg);
    wire logic [6:0] wlsb_wr = wdata_reg[WLSB_LSB +: 7];
    wire logic [6:0] wlsb_ok = (wlsb_wr < WLSB_MIN) ? WLSB_MIN : wlsb_wr;
    wire logic       lock_eff = lock_in & ~sleep_out;
    wire logic [14:0] ang_up  = {lock_eff, agc_in, angle_in};
    wire logic [14:0] cust_up = {wake_thresh_out, gain_out, 5'h00};

    // Two-flop synchronisers for the chip select, mode, pulse interface and link clock pins and for the link-side write toggle.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cs_n_s1_reg <= 1'b1;
            cs_n_s2_reg <= 1'b1;
            mode_s1_reg <= 1'b0;
            mode_s2_reg <= 1'b0;
            pwmi_s1_reg <= 1'b0;
            pwmi_s2_reg <= 1'b0;
            lclk_s1_reg <= 1'b0;
            lclk_s2_reg <= 1'b0;
            lclk_s3_reg <= 1'b0;
            wtog_s1_reg <= 1'b0;
            wtog_s2_reg <= 1'b0;
            wtog_s3_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            cs_n_s1_reg <= cs_n_in;
            cs_n_s2_reg <= cs_n_s1_reg;
            mode_s1_reg <= link_mode_in;
            mode_s2_reg <= mode_s1_reg;
            pwmi_s1_reg <= pwm_iface_in;
            pwmi_s2_reg <= pwmi_s1_reg;
            lclk_s1_reg <= link_clk_in;
            lclk_s2_reg <= lclk_s1_reg;
            lclk_s3_reg <= lclk_s2_reg;
            wtog_s1_reg <= wtog_reg;
            wtog_s2_reg <= wtog_s1_reg;
            wtog_s3_reg <= wtog_s2_reg;
        end
    end

    // Connection mode; three-wire until the mode pin asks otherwise.
    // The timeout watches link clock edges and aborts a stalled two-wire frame.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            two_wire_out <= 1'b0;
            frame_reg    <= 1'b0;
            tmo_reg      <= 10'h000;
            abort_reg    <= 1'b0;
        end
        else if (ce_in)
        begin
            two_wire_out <= mode_s2_reg;
            abort_reg    <= tmo_hit;
            if (lclk_rise)
            begin
                frame_reg <= 1'b1;
                tmo_reg   <= 10'h000;
            end
            else if (tmo_hit)
            begin
                frame_reg <= 1'b0;
                tmo_reg   <= 10'h000;
            end
            else if (frame_reg)
            begin
                tmo_reg <= tmo_reg + 10'h001;
            end
        end
    end

    // Read words are frozen for the whole frame so the link sees stable data.
    // They are taken from the angle only between frames, trading freshness for coherence.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            angle_word_reg <= 16'h0000;
            cust_word_reg  <= 16'h0000;
        end
        else if (ce_in && idle)
        begin
            angle_word_reg <= {ang_up, even_par(ang_up)};
            cust_word_reg  <= {cust_up, even_par(cust_up)};
        end
    end

    // Customer settings; the gain starts from the stored value after reset.
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            gain_out        <= GAIN_RESET;
            gain_ld_reg     <= 1'b0;
            wake_thresh_out <= WLSB_RESET;
            sleep_req_reg   <= 1'b0;
            sleep_out       <= 1'b0;
        end
        else if (ce_in)
        begin
            gain_ld_reg <= 1'b1;
            if (!gain_ld_reg)
            begin
                gain_out <= otp_gain_in;
            end
            else if (wr_evt && wcmd_reg == CMD_WR_CUST)
            begin
                gain_out        <= wdata_reg[GAIN_LSB +: 3];
                wake_thresh_out <= wlsb_ok;
            end
            if (wr_evt && wcmd_reg == CMD_WR_CONFIG)
            begin
                sleep_req_reg <= wdata_reg[SLEEP_BIT];
            end
            sleep_out <= sleep_req_reg & ~pwmi_s2_reg;
        end
    end

    // Link side: count rising edges and shift command and write data in.
    always_ff @(posedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            cnt_reg <= 5'h00;
            cmd_reg <= 5'h00;
            wsh_reg <= 16'h0000;
        end
        else
        begin
            if (cnt_reg != CNT_FRAME_END)
            begin
                cnt_reg <= cnt_reg + 5'h01;
            end
            if (cnt_reg < CNT_CMD_DONE)
            begin
                cmd_reg <= {cmd_reg[3:0], serial_data_line_in};
            end
            else if (is_write)
            begin
                wsh_reg <= {wsh_reg[14:0], serial_data_line_in};
            end
        end
    end

    // Finished write: word and command are parked and a toggle tells the core.
    // Only power-on reset clears these so a chip select edge makes no false event.
    always_ff @(posedge link_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wdata_reg <= 16'h0000;
            wcmd_reg  <= 5'h00;
            wtog_reg  <= 1'b0;
        end
        else if (link_rst_n && cnt_reg == CNT_LAST_DATA && is_write)
        begin
            wdata_reg <= {wsh_reg[14:0], serial_data_line_in};
            wcmd_reg  <= cmd_reg;
            wtog_reg  <= ~wtog_reg;
        end
    end

    // Read data leaves on falling edges, half a clock after each rising edge.
    // The line turns round only after the controller has had half a clock to let go.
    always_ff @(negedge link_clk_in or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            serial_data_line_oe_out <= 1'b0;
            serial_data_line_out    <= 1'b0;
            rsh_reg                 <= 16'h0000;
        end
        else if (cnt_reg == CNT_CMD_DONE && is_read)
        begin
            serial_data_line_oe_out <= 1'b1;
            serial_data_line_out    <= rd_word[15];
            rsh_reg                 <= {rd_word[14:0], 1'b0};
        end
        else if (cnt_reg == CNT_FRAME_END)
        begin
            serial_data_line_oe_out <= 1'b0;
        end
        else if (serial_data_line_oe_out)
        begin
            serial_data_line_out <= rsh_reg[15];
            rsh_reg              <= {rsh_reg[14:0], 1'b0};
        end
    end

    // Pulse-width output runs from the core clock only.
    asp_pwm_gen #(
        .LSB_CYC (PWM_LSB_CYC)
    ) u_pwm (
        .clk_in    (ref_clk_in),
        .resetn_in (resetn_in),
        .ce_in     (ce_in),
        .pos_in    (angle_in),
        .valid_in  (angle_valid_in),
        .pwm_out   (pwm_out)
    );

    a_drive_not_early: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        cnt_reg < CNT_CMD_DONE |-> !serial_data_line_oe_out)
        else $error("data line driven before command complete");

    a_read_msb_first: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        cnt_reg == CNT_CMD_DONE && is_read |-> serial_data_line_oe_out && serial_data_line_out == rd_word[15])
        else $error("first read bit is not D15");

    a_ext_no_drive: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        is_ext && cnt_reg > CNT_CMD_DONE |-> !serial_data_line_oe_out)
        else $error("extended command drove read data");

    a_cmd_shift_in: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        cnt_reg < CNT_CMD_DONE |=> cmd_reg[4:1] == $past(cmd_reg[3:0]))
        else $error("command bits not shifted on rising edge");

    a_cs_floats_line: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        cs_n_s2_reg && !two_wire_out |-> !serial_data_line_oe_out)
        else $error("data line driven after chip select release");

    a_timeout_abort: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && tmo_hit && !lclk_rise |=> abort_reg && !frame_reg)
        else $error("two-wire frame not abandoned at timeout");

    a_gain_write: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && gain_ld_reg && wr_evt && wcmd_reg == CMD_WR_CUST
        |=> gain_out == $past(wdata_reg[GAIN_LSB +: 3]))
        else $error("gain write not applied");

    a_pwm_no_sleep: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && pwmi_s2_reg |=> !sleep_out)
        else $error("sleep entered with pulse interface");

    a_angle_parity: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ^angle_word_reg == 1'b0)
        else $error("angle word parity not even");

    a_mode_default: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
        ce_in && !mode_s2_reg |=> !two_wire_out)
        else $error("left three-wire mode without request");

endmodule // asp_angle_out

// [asp_pkg.sv]
// Shared constants for the angle serial and pulse-width output block.
package asp_pkg;

    // Serial frame shape.
    localparam int        CMD_BITS    = 5;
    localparam int        DATA_BITS   = 16;
    localparam logic [4:0] CNT_CMD_DONE = 5'h05;
    localparam logic [4:0] CNT_LAST_DATA = 5'h14;
    localparam logic [4:0] CNT_FRAME_END = 5'h15;

    // Command codes.
    localparam logic [4:0] CMD_RD_ANGLE  = 5'h00;
    localparam logic [4:0] CMD_RD_CUST   = 5'h07;
    localparam logic [4:0] CMD_WR_CONFIG = 5'h11;
    localparam logic [4:0] CMD_WR_CUST   = 5'h17;
    localparam logic [1:0] CMD_EXT_TOP   = 2'h3;

    // Field positions and reset values.
    localparam int         GAIN_LSB      = 6;
    localparam int         WLSB_LSB      = 9;
    localparam int         SLEEP_BIT     = 15;
    localparam logic [6:0] WLSB_RESET    = 7'h04;
    localparam logic [6:0] WLSB_MIN      = 7'h04;
    localparam logic [2:0] GAIN_RESET    = 3'h0;

    // Timing.
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         PWM_LSB_NS    = 556;
    localparam int         PWM_LSB_CYC   = PWM_LSB_NS / CLK_PERIOD_NS;
    localparam logic [8:0] PWM_LAST_SLOT = 9'h100;
    localparam int         TMO_US        = 20;
    localparam int         TMO_CYC       = (TMO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [asp_pwm_gen.sv]
// Pulse-width generator that encodes an 8-bit angle as a high time of position plus one slot.
module asp_pwm_gen
    import asp_pkg::*;
#(
    parameter int LSB_CYC = PWM_LSB_CYC
)
(
    // Clock and reset.
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       ce_in,
    // Angle source.
    input  wire logic [7:0] pos_in,
    input  wire logic       valid_in,
    // Pulse output.
    output logic            pwm_out
);

    logic [15:0] pre_reg;
    logic [8:0]  slot_reg;
    logic [7:0]  pos_reg;

    // Slot timing: one tick per slot, 257 slots per period.
    wire logic       tick      = (pre_reg == 16'(LSB_CYC - 1));
    wire logic       wrap      = tick && (slot_reg == PWM_LAST_SLOT);
    wire logic [8:0] slot_next = wrap ? 9'h000 : slot_reg + 9'h001;
    wire logic       high_next = valid_in && (slot_reg <= {1'b0, pos_reg});

    // Prescaler, slot counter and a position that changes only at the period edge.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pre_reg  <= 16'h0000;
            slot_reg <= 9'h000;
            pos_reg  <= 8'h00;
            pwm_out  <= 1'b0;
        end
        else if (ce_in)
        begin
            pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
            if (tick)
            begin
                slot_reg <= slot_next;
            end
            if (wrap)
            begin
                pos_reg <= pos_in;
            end
            pwm_out <= high_next;
        end
    end

    // A lost angle must pull the line low at once, whatever the slot.
    a_pwm_invalid_low: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && !valid_in |=> !pwm_out)
        else $error("pwm high while angle invalid");

    a_pwm_period_wrap: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && tick && slot_reg == PWM_LAST_SLOT |=> slot_reg == 9'h000)
        else $error("pwm period not 257 slots");

    a_pwm_high_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $fell(pwm_out) && $past(valid_in) && $past(ce_in) |-> $past(slot_reg) == pos_reg + 9'h001)
        else $error("pwm high time not position plus one");

    a_pwm_pos_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !(ce_in && wrap) |=> $stable(pos_reg))
        else $error("pwm position changed mid period");

endmodule // asp_pwm_gen

// [asp_ctrl_model.sv]
// Controller model that runs serial frames on the three-wire link.
module asp_ctrl_model
(
    // Link outputs.
    output logic        cs_n_out,
    output logic        link_clk_out,
    output logic        data_out,
    output logic        data_oe_out,
    // Observed line.
    input  wire logic   line_in,
    input  wire logic   dut_oe_in,
    // Frame result.
    output logic        done_out,
    output logic [37:0] res_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle link: clock parked low, select high, line released.
    initial
    begin
        cs_n_out = 1'b1;
        link_clk_out = 1'b0;
        data_out = 1'b0;
        data_oe_out = 1'b0;
        done_out = 1'b0;
        res_out = '0;
    end

    // One frame; the clock runs only inside it so the device never sees stray edges.
    task automatic frame(input logic [4:0] cmd, input logic [15:0] wd, input int nbits,
                         input bit hold_cs);
        logic [20:0] sh;
        logic [20:0] oev;
        logic [20:0] bits;
        sh = '0;
        oev = '0;
        bits = {cmd, wd};
        #7;
        data_oe_out = 1'b1;
        data_out = bits[20];
        cs_n_out = 1'b0;
        for (int i = 1; i <= nbits; i++)
        begin
            #40 link_clk_out = 1'b1;
            sh = {sh[19:0], line_in};
            oev = {oev[19:0], dut_oe_in};
            #20;
            if (i == 5 && !cmd[4])
                data_oe_out = 1'b0;
            #20 link_clk_out = 1'b0;
            if (i < 21)
                data_out = bits[20 - i];
        end
        if (!hold_cs)
            cs_n_out = 1'b1;
        data_oe_out = 1'b0;
        #30;
        res_out = {dut_oe_in, oev, sh[15:0]};
        if (nbits == 21)
        begin
            done_out = 1'b1;
            #1 done_out = 1'b0;
        end
        #100;
    endtask

endmodule // asp_ctrl_model

// [tb_asp_angle_out.sv]
// Self-checking bench for the angle serial and pulse-width output block.
module tb_asp_angle_out
    import asp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk_in = 1'b0;
    logic        resetn_in;
    logic        link_mode_in;
    logic        pwm_iface_in;
    logic [2:0]  otp_gain_in;
    logic [7:0]  angle_in;
    logic        angle_valid_in;
    logic        lock_in;
    logic [5:0]  agc_in;
    logic        cs_n, lclk, m_d, m_oe, m_done, d_out, d_oe, pwm, sleep, two_wire;
    logic [37:0] m_res;
    logic [2:0]  gain;
    logic [6:0]  wthr;
    logic [6:0]  w;
    logic [7:0]  r;
    logic [7:0]  lfsr = 8'h09;
    logic        fill = 1'b0;
    logic        pwm_d = 1'b0;
    logic [31:0] hi_c = '0;
    logic [31:0] lo_c = '0;
    logic [37:0] rd_q[$];
    logic [31:0] pw_q[$];
    int          n_mismatch = 0;
    int          checks = 0;
    wire         line;

    // Nobody driving: the line toggles so a stale value never passes for data.
    assign line = d_oe ? d_out : (m_oe ? m_d : fill);

    asp_angle_out dut (.ref_clk_in, .resetn_in, .ce_in(1'b1), .link_clk_in(lclk),
        .cs_n_in(cs_n), .serial_data_line_in(line), .serial_data_line_out(d_out),
        .serial_data_line_oe_out(d_oe), .link_mode_in, .pwm_iface_in, .otp_gain_in,
        .angle_in, .angle_valid_in, .lock_in, .agc_in, .pwm_out(pwm), .gain_out(gain),
        .wake_thresh_out(wthr), .sleep_out(sleep), .two_wire_out(two_wire));

    asp_ctrl_model m (.cs_n_out(cs_n), .link_clk_out(lclk), .data_out(m_d),
        .data_oe_out(m_oe), .line_in(line), .dut_oe_in(d_oe), .done_out(m_done),
        .res_out(m_res));

    // Core clock.
    initial
    begin
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    // Filler pattern for the released line.
    always @(posedge ref_clk_in) fill <= ~fill;

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        return lfsr;
    endfunction

    task automatic check(input logic [37:0] seen, input logic [37:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    // Full frame; reads expect the payload with even parity and the drive window edges 6..21.
    task automatic xfer(input logic [4:0] cmd, input logic [15:0] wd, input logic [14:0] d);
        if (cmd[4])
            rd_q.push_back({1'b0, 21'h000000, wd});
        else
            rd_q.push_back({1'b0, 21'h00FFFF, d, ^d});
        m.frame(cmd, wd, 21, 1'b0);
        settle(1);
    endtask

    // Period k is noted after its start, so the stale period before it is never compared.
    task automatic pwm_case(input logic [7:0] a);
        @(posedge pwm);
        settle(1);
        angle_in = a;
        @(posedge pwm);
        settle(3);
        pw_q.push_back((32'(a) + 1) * PWM_LSB_CYC);
        settle(100);
        angle_in = ~a;
        @(posedge pwm);
        settle(3);
    endtask

    // Serial results are compared in frame order.
    always @(posedge m_done)
        check(m_res, rd_q.size() > 0 ? rd_q.pop_front() : 38'bx, "frame");

    // Pulse timing is measured rise to rise.
    always @(posedge ref_clk_in)
    begin
        pwm_d <= pwm;
        if (pwm && !pwm_d)
        begin
            if (pw_q.size() > 0)
            begin
                check(hi_c, pw_q.pop_front(), "pwm_high");
                check(hi_c + lo_c, 257 * PWM_LSB_CYC, "pwm_period");
            end
            hi_c <= 32'h1;
            lo_c <= 32'h0;
        end
        else if (pwm)
            hi_c <= hi_c + 32'h1;
        else
            lo_c <= lo_c + 32'h1;
    end

    // A hang counts as a mismatch.
    initial
    begin
        repeat (90000) @(posedge ref_clk_in);
        n_mismatch++;
        summarize();
    end

    // Main sequence.
    initial
    begin
        resetn_in = 1'b0;
        link_mode_in = 1'b0;
        pwm_iface_in = 1'b0;
        r = rnd();
        otp_gain_in = r[2:0];
        angle_in = 8'h00;
        angle_valid_in = 1'b1;
        lock_in = 1'b1;
        agc_in = 6'h00;
        settle(3);
        resetn_in = 1'b1;
        settle(5);
        check(gain, otp_gain_in, "gain_out");
        check(two_wire, 1'b0, "two_wire_out");
        r = rnd();
        angle_in = r;
        agc_in = r[5:0] ^ 6'h15;
        xfer(CMD_RD_ANGLE, 16'h0000, {lock_in, agc_in, angle_in});
        for (int g = 0; g < 8; g++)
        begin
            w = g[0] ? 7'h7F : 7'(g);
            xfer(CMD_WR_CUST, {w, g[2:0], 6'h00}, 15'h0000);
            w = (w < WLSB_MIN) ? WLSB_MIN : w;
            settle(10);
            check(gain, g[2:0], "gain_out");
            check(wthr, w, "wake_thresh_out");
            xfer(CMD_RD_CUST, 16'h0000, {w, g[2:0], 5'h00});
        end
        xfer(5'h1F, 16'h0000, 15'h0000);
        m.frame(CMD_WR_CUST, 16'h0000, 8, 1'b0);
        settle(10);
        check(gain, 3'h7, "gain_out");
        xfer(5'h05, 16'h0000, 15'h0000);
        pwm_iface_in = 1'b1;
        settle(5);
        xfer(CMD_WR_CONFIG, 16'h8000, 15'h0000);
        settle(10);
        check(sleep, 1'b0, "sleep_out");
        pwm_iface_in = 1'b0;
        settle(5);
        xfer(CMD_WR_CONFIG, 16'h8000, 15'h0000);
        settle(10);
        check(sleep, 1'b1, "sleep_out");
        xfer(CMD_RD_ANGLE, 16'h0000, {1'b0, agc_in, angle_in});
        xfer(CMD_WR_CONFIG, 16'h0000, 15'h0000);
        settle(10);
        link_mode_in = 1'b1;
        settle(5);
        check(two_wire, 1'b1, "two_wire_out");
        m.frame(CMD_RD_ANGLE, 16'h0000, 3, 1'b1);
        settle(1200);
        xfer(CMD_RD_ANGLE, 16'h0000, {lock_in, agc_in, angle_in});
        link_mode_in = 1'b0;
        settle(5);
        for (int k = 0; k < 3; k++)
            pwm_case(k == 0 ? 8'h00 : (k == 1 ? 8'hFF : rnd()));
        angle_valid_in = 1'b0;
        settle(2);
        repeat (300)
        begin
            check(pwm, 1'b0, "pwm_out");
            settle(1);
        end
        summarize();
    end

endmodule // tb_asp_angle_out
